// File: rtl/inertia_motor_pkg.sv
// Shared constants, settings layout and motion states for the inertia motor
// step controller. Assumes a single 40 MHz system clock.
package inertia_motor_pkg;

  // System clock rate in hertz.
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned CLK_KHZ = CLK_HZ / 1000;

  // Field widths.
  localparam int unsigned VEL_W = 11;
  localparam int unsigned ACC_W = 17;
  localparam int unsigned VOLT_W = 7;
  localparam int unsigned POS_W = 32;
  localparam int unsigned POT_W = 8;
  localparam int unsigned PHASE_W = 27;
  localparam int unsigned CNT_W = 27;

  // Legal ranges of the programmable settings.
  localparam logic [16:0] VEL_MIN = 17'h00001;
  localparam logic [16:0] VEL_MAX = 17'h007D0;
  localparam logic [16:0] ACC_MIN = 17'h00001;
  localparam logic [16:0] ACC_MAX = 17'h186A0;
  localparam logic [16:0] VOLT_MIN = 17'h00055;
  localparam logic [16:0] VOLT_MAX = 17'h0007D;
  localparam logic [16:0] JOG_STEP_MIN = 17'h00001;
  localparam logic [16:0] JOG_STEP_MAX = 17'h007D0;

  // Pot deflection is scaled by full scale 2^POT_SHIFT.
  localparam int unsigned POT_SHIFT = 7;

  // Times in milliseconds and the cycle counts derived from them.
  localparam int unsigned HOLD_MS = 2000;
  localparam int unsigned IDENT_MS = 1000;
  localparam int unsigned BLINK_MS = 125;
  localparam int unsigned HOLD_CYCLES = HOLD_MS * CLK_KHZ;
  localparam int unsigned IDENT_CYCLES = IDENT_MS * CLK_KHZ;
  localparam int unsigned BLINK_CYCLES = BLINK_MS * CLK_KHZ;

  // Persistable settings, as loaded by the host or restored from storage.
  typedef struct packed {
    logic [VEL_W-1:0] moveVel;
    logic [ACC_W-1:0] moveAcc;
    logic [VOLT_W-1:0] peakVolt;
    logic jogContinuous;
    logic [VEL_W-1:0] jogStep;
    logic [VEL_W-1:0] jogVel;
    logic [ACC_W-1:0] jogAcc;
    logic keyTargetMode;
    logic signed [POS_W-1:0] topPos;
    logic signed [POS_W-1:0] bottomPos;
    logic [VEL_W-1:0] potMaxVel;
  } settings_t;

  // Settings in force after reset until storage or host supplies others.
  localparam settings_t DEF_SETTINGS = '{
    moveVel: 11'h1F4, moveAcc: 17'h186A0, peakVolt: 7'h6E,
    jogContinuous: 1'b0, jogStep: 11'h0FA, jogVel: 11'h1F4,
    jogAcc: 17'h186A0, keyTargetMode: 1'b0, topPos: 32'h00000000,
    bottomPos: 32'h00000000, potMaxVel: 11'h3E8};

  typedef enum logic [1:0] {
    MOT_IDLE = 2'b00,
    MOT_TARGET = 2'b01,
    MOT_FREE = 2'b10
  } motion_t;

  // Holds a value inside an inclusive range.
  function automatic logic [16:0] limit(logic [16:0] v, logic [16:0] lo, logic [16:0] hi);
    limit = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // Forces every ranged field of a settings word into its legal range.
  function automatic settings_t clamp_settings(settings_t c);
    settings_t r;
    r = c;
    r.moveVel = VEL_W'(limit(17'(c.moveVel), VEL_MIN, VEL_MAX));
    r.moveAcc = limit(c.moveAcc, ACC_MIN, ACC_MAX);
    r.peakVolt = VOLT_W'(limit(17'(c.peakVolt), VOLT_MIN, VOLT_MAX));
    r.jogStep = VEL_W'(limit(17'(c.jogStep), JOG_STEP_MIN, JOG_STEP_MAX));
    r.jogVel = VEL_W'(limit(17'(c.jogVel), VEL_MIN, VEL_MAX));
    r.jogAcc = limit(c.jogAcc, ACC_MIN, ACC_MAX);
    r.potMaxVel = VEL_W'(limit(17'(c.potMaxVel), VEL_MIN, VEL_MAX));
    return r;
  endfunction

endpackage

// File: rtl/phase_accum.sv
// Phase accumulator: adds a rate each clock and ticks once per CLK_HZ of sum,
// so the tick rate in hertz equals the increment. Assumes one clock domain.
`timescale 1ns/10ps
`default_nettype none
module phase_accum (
  input wire logic sys_clk, // System clock.
  input wire logic reset_n, // Asynchronous reset, active low.
  input wire logic clear, // Restarts the phase from CLK_HZ - 2.
  input wire logic [inertia_motor_pkg::ACC_W-1:0] increment, // Rate in events per second.
  output logic tick // One-cycle event pulse.
);

  typedef struct packed {
    logic [inertia_motor_pkg::PHASE_W-1:0] phase;
  } accum_t;

  accum_t s;
  accum_t next_s;
  logic [inertia_motor_pkg::PHASE_W-1:0] sum;

  ////////////////////////////////////////////////////////////////////////////
  // The wrap is exact, so the long-run rate carries no rounding drift.
  always_comb
  begin
    sum = s.phase + inertia_motor_pkg::PHASE_W'(increment);
    tick = !clear && (sum >= inertia_motor_pkg::PHASE_W'(inertia_motor_pkg::CLK_HZ));
    next_s = s;
    // Preloaded so a run's first tick comes two clocks after it starts at an increment of 1, one clock at 2 or more.
    if (clear)
      next_s.phase = inertia_motor_pkg::PHASE_W'(inertia_motor_pkg::CLK_HZ - 2);
    else if (tick)
      next_s.phase = sum - inertia_motor_pkg::PHASE_W'(inertia_motor_pkg::CLK_HZ);
    else
      next_s.phase = sum;
  end

  // State register.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      s <= '0;
    else
      s <= next_s;
  end

endmodule
`default_nettype wire

// File: rtl/inertia_motor_step_control.sv
// Step controller for one piezo inertia motor channel: ramps, position count,
// moves, jogs, panel buttons, pot, identify and settings storage.
// Assumes all inputs are synchronous to sys_clk and storage answers nvReady.
//
// Summary of operation
// - Zero clears the position count where the motor now stands.
// - Stop ends all stepping, cancelling any move or jog.
// - Moving indicator is high while a move, jog or pot run is in progress.
// - Move velocity programmable from 1 to 2000 steps per second.
// - Move acceleration 1 to 100000 steps/s/s; rate ramps up to velocity.
// - Each step is a ramp up to peak drive then a fast fall.
// - Peak drive setting is held between 85 and 125 volts.
// - Increment jog moves jog step count; repeats while request held.
// - Continuous jog accelerates to jog rate and runs while held.
// - Jog increment programmable from 1 to 2000 pulses.
// - Jog velocity and acceleration have their own ranged settings.
// - Host moves and target-mode buttons use move velocity and acceleration.
// - In jog button mode a button press jogs with jog settings.
// - In target mode each button drives to its own stored position.
// - Both buttons held two seconds clears the position count.
// - Pot centred stays still; deflection sets direction and speed.
// - Pot full-deflection rate programmable from 1 to 2000 pulses/s.
// - Save request stores settings; they are restored at power-up.
// - Host-loaded settings replace any restored ones.
// - Only an enabled channel drives; its indicator shows the enable.
// - Identify blinks the channel indicator for a fixed time.
// - Active shows fault-free running; error shows a detected fault.
`timescale 1ns/10ps
`default_nettype none
module inertia_motor_step_control #(
  parameter int unsigned HOLD_CYCLES = inertia_motor_pkg::HOLD_CYCLES,
  parameter int unsigned IDENT_CYCLES = inertia_motor_pkg::IDENT_CYCLES,
  parameter int unsigned BLINK_CYCLES = inertia_motor_pkg::BLINK_CYCLES
) (
  input wire logic sys_clk, // System clock, 40 MHz.
  input wire logic reset_n, // Asynchronous reset, active low.
  input wire logic chanEnable, // Channel drive enable.
  input wire logic faultIn, // Fault detected by the drive stage.
  input wire inertia_motor_pkg::settings_t hostSettings, // Settings from host.
  input wire logic hostLoad, // Pulse: apply hostSettings.
  input wire logic saveToNonvolatile, // Pulse: store current settings.
  input wire inertia_motor_pkg::settings_t nvRestore, // Settings read from storage.
  input wire logic nvReady, // Storage has valid settings.
  input wire logic zeroCmd, // Pulse: zero the position count.
  input wire logic stopCmd, // Pulse: halt motion.
  input wire logic moveCmd, // Pulse: absolute move to moveTarget.
  input wire logic signed [31:0] moveTarget, // Absolute target in steps.
  input wire logic jogFwd, // Host jog forward, held level.
  input wire logic jogRev, // Host jog reverse, held level.
  input wire logic identifyCmd, // Pulse: blink the channel indicator.
  input wire logic btnTop, // Top panel button, high while pressed.
  input wire logic btnBottom, // Bottom panel button, high while pressed.
  input wire logic signed [7:0] potDeflection, // Pot position, zero at centre.
  output logic [6:0] driveLevel, // Sawtooth drive level in volts.
  output logic stepDir, // Direction of the last step, high forward.
  output logic signed [31:0] position, // Position count in steps.
  output logic moving, // High while steps are produced.
  output logic activeLed, // Running without fault.
  output logic errorLed, // Fault present.
  output logic chanLed, // Channel indicator.
  output logic nvWrite, // Pulse: write nvData to storage.
  output inertia_motor_pkg::settings_t nvData // Settings to store.
);

  ////////////////////////////////////////////////////////////////////////////
  // State of the controller.
  typedef struct packed {
    inertia_motor_pkg::motion_t mot;
    logic booted;
    inertia_motor_pkg::settings_t cfg;
    logic signed [31:0] pos;
    logic signed [31:0] target;
    logic dir;
    logic useJog;
    logic potMode;
    logic [10:0] curVel;
    logic ramp;
    logic [6:0] level;
    logic moving;
    logic activeLed;
    logic errorLed;
    logic chanLed;
    logic nvWrite;
    logic [26:0] identCnt;
    logic [26:0] blinkCnt;
    logic blink;
    logic [26:0] holdCnt;
    logic holdDone;
    logic [1:0] btnPrev;
  } ctrl_t;

  localparam ctrl_t RESET_STATE = '{
    mot: inertia_motor_pkg::MOT_IDLE, booted: 1'b0,
    cfg: inertia_motor_pkg::DEF_SETTINGS, pos: 32'h00000000,
    target: 32'h00000000, dir: 1'b1, useJog: 1'b0, potMode: 1'b0,
    curVel: 11'h000, ramp: 1'b0, level: 7'h00, moving: 1'b0,
    activeLed: 1'b0, errorLed: 1'b0, chanLed: 1'b0, nvWrite: 1'b0,
    identCnt: 27'h0000000, blinkCnt: 27'h0000000, blink: 1'b0,
    holdCnt: 27'h0000000, holdDone: 1'b0, btnPrev: 2'h0};

  ctrl_t s;
  ctrl_t next_s;

  logic [32:0] diff;
  logic [32:0] remDist;
  logic [16:0] accNow;
  logic [10:0] limitVel;
  logic [7:0] potMag;
  logic [18:0] potProd;
  logic [10:0] potVel;
  logic [63:0] velSq;
  logic [63:0] brakeDist;
  logic brake;
  logic stepTick;
  logic accelTick;
  logic halt;
  logic zeroNow;
  logic fwdHeld;
  logic revHeld;
  logic topEdge;
  logic bottomEdge;
  logic atTarget;
  logic idleNow;

  ////////////////////////////////////////////////////////////////////////////
  // Step and acceleration timing, both as exact phase accumulators.
  assign idleNow = (s.mot == inertia_motor_pkg::MOT_IDLE);

  phase_accum stepGen (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clear(idleNow),
    .increment(17'(s.curVel)),
    .tick(stepTick)
  );

  phase_accum accelGen (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clear(idleNow),
    .increment(accNow),
    .tick(accelTick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Derived values: distance left, active profile and pot speed.
  always_comb
  begin
    diff = {s.target[31], s.target} - {s.pos[31], s.pos};
    remDist = diff[32] ? (33'h000000000 - diff) : diff;
    atTarget = (remDist == 33'h000000000);
    // Jogs run on their own profile, host and target moves on the move one.
    accNow = s.useJog ? s.cfg.jogAcc : s.cfg.moveAcc;
    // Pot magnitude; -128 maps to 128, which is full scale.
    potMag = potDeflection[7] ? (8'h00 - potDeflection) : potDeflection;
    potProd = 19'(s.cfg.potMaxVel) * 19'(potMag);
    potVel = potProd[17:7];
    if (s.mot == inertia_motor_pkg::MOT_FREE)
      limitVel = s.potMode ? potVel : s.cfg.jogVel;
    else
      limitVel = s.useJog ? s.cfg.jogVel : s.cfg.moveVel;
    // Brake once v^2 reaches 2*a*d, the distance needed to stop at the target.
    velSq = 64'(s.curVel) * 64'(s.curVel);
    brakeDist = 64'(accNow) * 64'(remDist) * 64'h0000000000000002;
    brake = (s.mot == inertia_motor_pkg::MOT_TARGET) && (velSq >= brakeDist);
  end

  // Request decoding from host, buttons and faults.
  always_comb
  begin
    halt = stopCmd || faultIn || !chanEnable;
    zeroNow = zeroCmd || (btnTop && btnBottom && !s.holdDone
      && (s.holdCnt == 27'(HOLD_CYCLES - 1)));
    // Buttons jog only in jog mode and only when pressed alone.
    fwdHeld = jogFwd || (!s.cfg.keyTargetMode && btnTop && !btnBottom);
    revHeld = jogRev || (!s.cfg.keyTargetMode && btnBottom && !btnTop);
    topEdge = s.cfg.keyTargetMode && btnTop && !btnBottom && !s.btnPrev[1];
    bottomEdge = s.cfg.keyTargetMode && btnBottom && !btnTop && !s.btnPrev[0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic for the whole controller.
  always_comb
  begin
    next_s = s;
    next_s.nvWrite = 1'b0;
    next_s.btnPrev = {btnTop, btnBottom};

    // Settings: restore once after power-up, host load always wins.
    if (!s.booted && nvReady)
    begin
      next_s.cfg = inertia_motor_pkg::clamp_settings(nvRestore);
      next_s.booted = 1'b1;
    end
    if (hostLoad)
    begin
      next_s.cfg = inertia_motor_pkg::clamp_settings(hostSettings);
      next_s.booted = 1'b1;
    end
    // The stored word is the live settings register, so it is always current.
    if (saveToNonvolatile)
      next_s.nvWrite = 1'b1;

    // Motion sequencing.
    case (s.mot)
      inertia_motor_pkg::MOT_IDLE:
      begin
        next_s.curVel = 11'h001;
        if (moveCmd)
        begin
          next_s.target = moveTarget;
          next_s.useJog = 1'b0;
          next_s.mot = inertia_motor_pkg::MOT_TARGET;
        end
        else if (topEdge || bottomEdge)
        begin
          next_s.target = topEdge ? s.cfg.topPos : s.cfg.bottomPos;
          next_s.useJog = 1'b0;
          next_s.mot = inertia_motor_pkg::MOT_TARGET;
        end
        else if (fwdHeld != revHeld)
        begin
          next_s.useJog = 1'b1;
          next_s.potMode = 1'b0;
          next_s.dir = fwdHeld;
          if (s.cfg.jogContinuous)
            next_s.mot = inertia_motor_pkg::MOT_FREE;
          else
          begin
            next_s.target = fwdHeld ? (s.pos + 32'(s.cfg.jogStep))
                                    : (s.pos - 32'(s.cfg.jogStep));
            next_s.mot = inertia_motor_pkg::MOT_TARGET;
          end
        end
        else if (potVel != 11'h000)
        begin
          next_s.useJog = 1'b0;
          next_s.potMode = 1'b1;
          next_s.dir = !potDeflection[7];
          next_s.mot = inertia_motor_pkg::MOT_FREE;
        end
      end
      inertia_motor_pkg::MOT_TARGET:
      begin
        // A new host move retargets on the fly from the present speed.
        if (moveCmd)
        begin
          next_s.target = moveTarget;
          next_s.useJog = 1'b0;
        end
        else if (atTarget)
        begin
          if (s.useJog && !s.cfg.jogContinuous && (s.dir ? fwdHeld : revHeld))
          begin
            next_s.target = s.dir ? (s.pos + 32'(s.cfg.jogStep))
                                  : (s.pos - 32'(s.cfg.jogStep));
            next_s.curVel = 11'h001;
          end
          else
            next_s.mot = inertia_motor_pkg::MOT_IDLE;
        end
        else
          next_s.dir = !diff[32];
      end
      inertia_motor_pkg::MOT_FREE:
      begin
        if (s.potMode)
        begin
          // Slider back at centre or swung past it ends this run.
          if ((potVel == 11'h000) || (potDeflection[7] == s.dir))
            next_s.mot = inertia_motor_pkg::MOT_IDLE;
        end
        else if (!(s.dir ? fwdHeld : revHeld))
          next_s.mot = inertia_motor_pkg::MOT_IDLE;
      end
      default:
        next_s.mot = inertia_motor_pkg::MOT_IDLE;
    endcase

    // Velocity ramp, one step/s per acceleration tick.
    if (!idleNow && accelTick)
    begin
      if (brake)
      begin
        if (s.curVel > 11'h001)
          next_s.curVel = s.curVel - 11'h001;
      end
      else if (s.curVel < limitVel)
        next_s.curVel = s.curVel + 11'h001;
      else if (s.curVel > limitVel)
        next_s.curVel = s.curVel - 11'h001;
    end

    // Issue a step and follow it in the position count.
    if (!idleNow && stepTick && !(s.mot == inertia_motor_pkg::MOT_TARGET && atTarget))
    begin
      next_s.pos = s.dir ? (s.pos + 32'h00000001) : (s.pos - 32'h00000001);
      next_s.ramp = 1'b1;
      next_s.level = 7'h00;
    end
    else if (s.ramp)
    begin
      // Rise one volt a clock, then drop to zero in a single clock.
      if (s.level >= s.cfg.peakVolt)
      begin
        next_s.ramp = 1'b0;
        next_s.level = 7'h00;
      end
      else
        next_s.level = s.level + 7'h01;
    end

    // Stop, fault and disable override all motion requests.
    if (halt)
    begin
      next_s.mot = inertia_motor_pkg::MOT_IDLE;
      next_s.ramp = 1'b0;
      next_s.level = 7'h00;
    end

    // Zero is applied last so it wins over a step in the same cycle.
    if (zeroNow)
      next_s.pos = 32'h00000000;

    // Both-button hold timer; it fires once per hold.
    if (btnTop && btnBottom)
    begin
      if (s.holdCnt == 27'(HOLD_CYCLES - 1))
        next_s.holdDone = 1'b1;
      else if (!s.holdDone)
        next_s.holdCnt = s.holdCnt + 27'h0000001;
    end
    else
    begin
      next_s.holdCnt = 27'h0000000;
      next_s.holdDone = 1'b0;
    end

    // Identify blink window.
    if (identifyCmd)
    begin
      next_s.identCnt = 27'(IDENT_CYCLES);
      next_s.blinkCnt = 27'h0000000;
      next_s.blink = 1'b0;
    end
    else if (s.identCnt != 27'h0000000)
    begin
      next_s.identCnt = s.identCnt - 27'h0000001;
      if (s.blinkCnt == 27'(BLINK_CYCLES - 1))
      begin
        next_s.blinkCnt = 27'h0000000;
        next_s.blink = !s.blink;
      end
      else
        next_s.blinkCnt = s.blinkCnt + 27'h0000001;
    end

    // Indicators, registered so every output comes from a flip-flop.
    next_s.moving = (next_s.mot != inertia_motor_pkg::MOT_IDLE);
    next_s.activeLed = !faultIn;
    next_s.errorLed = faultIn;
    next_s.chanLed = chanEnable && ((next_s.identCnt == 27'h0000000) || next_s.blink);
  end

  // State register.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      s <= RESET_STATE;
    else
      s <= next_s;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register.
  assign driveLevel = s.level;
  assign stepDir = s.dir;
  assign position = s.pos;
  assign moving = s.moving;
  assign activeLed = s.activeLed;
  assign errorLed = s.errorLed;
  assign chanLed = s.chanLed;
  assign nvWrite = s.nvWrite;
  assign nvData = s.cfg;

endmodule
`default_nettype wire

// File: tb/inertia_motor_step_control_props.sv
// Concurrent checks on the ports of the inertia motor step controller.
// Assumes one sys_clk domain with reset_n asynchronous and active low.
`timescale 1ns/10ps
`default_nettype none
module inertia_motor_step_control_props (
  input wire logic sys_clk, // System clock.
  input wire logic reset_n, // Reset, active low.
  input wire logic chanEnable, // Channel enable.
  input wire logic faultIn, // Fault input.
  input wire inertia_motor_pkg::settings_t hostSettings, // Host settings.
  input wire logic hostLoad, // Host load pulse.
  input wire logic saveToNonvolatile, // Save pulse.
  input wire logic zeroCmd, // Zero pulse.
  input wire logic stopCmd, // Stop pulse.
  input wire logic moveCmd, // Move pulse.
  input wire logic [6:0] driveLevel, // Drive level.
  input wire logic signed [31:0] position, // Position count.
  input wire logic moving, // Motion indicator.
  input wire logic activeLed, // Active status.
  input wire logic errorLed, // Error status.
  input wire logic nvWrite, // Storage write pulse.
  input wire inertia_motor_pkg::settings_t nvData // Live settings.
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////////
  // A change to a nonzero count must be one step; zeroing is the only jump.
  property p_zero; zeroCmd |=> position == 32'sh00000000; endproperty
  property p_stop; stopCmd |=> !moving; endproperty
  property p_halt; (faultIn || !chanEnable) |=> !moving; endproperty
  property p_start; (moveCmd && !stopCmd && !faultIn && chanEnable) |=> moving; endproperty
  property p_step;
    ($changed(position) && position != 32'sh00000000) |->
      (position == $past(position) + 32'sh1 || position == $past(position) - 32'sh1);
  endproperty
  property p_stepmove; ($changed(position) && position != 32'sh00000000) |-> $past(moving); endproperty
  property p_ramp; driveLevel != 7'h00 |-> driveLevel == $past(driveLevel) + 7'h01; endproperty
  property p_peak; driveLevel <= 7'h7D; endproperty
  property p_save; saveToNonvolatile |=> nvWrite; endproperty
  property p_host; hostLoad |=> nvData.topPos == $past(hostSettings.topPos); endproperty
  property p_fault; faultIn |=> (errorLed && !activeLed); endproperty
  a_zero: assert property (p_zero) else $error("zero did not clear position");
  a_stop: assert property (p_stop) else $error("still moving after stop");
  a_halt: assert property (p_halt) else $error("moving while halted");
  a_start: assert property (p_start) else $error("move did not start");
  a_step: assert property (p_step) else $error("position jumped");
  a_stepmove: assert property (p_stepmove) else $error("step while not moving");
  a_ramp: assert property (p_ramp) else $error("drive ramp broken");
  a_peak: assert property (p_peak) else $error("drive above limit");
  a_save: assert property (p_save) else $error("no storage write");
  a_host: assert property (p_host) else $error("host settings not taken");
  a_fault: assert property (p_fault) else $error("fault status wrong");
  c_move: cover property (moveCmd ##1 moving);
  c_step: cover property ($changed(position) && position != 32'sh00000000);
  c_save: cover property (nvWrite);
endmodule
`default_nettype wire

// File: tb/nv_store_model.sv
// Behavioural non-volatile settings store facing the controller.
// Assumes writes arrive as one-cycle nvWrite pulses on sys_clk.
`timescale 1ns/10ps
`default_nettype none
module nv_store_model (
  input wire logic sys_clk, // System clock.
  input wire logic nvWrite, // Write pulse.
  input wire inertia_motor_pkg::settings_t nvData, // Data to keep.
  output logic nvReady, // Store holds valid settings.
  output inertia_motor_pkg::settings_t nvRestore // Kept settings.
);
  // Starts out holding an earlier saved set, so a restore is visible.
  initial
  begin
    nvRestore = inertia_motor_pkg::DEF_SETTINGS;
    nvRestore.jogStep = 11'h00A;
    nvRestore.topPos = 32'sh00000003;
    // Keeps each written word across power cycles.
    forever @(posedge sys_clk)
      if (nvWrite)
        nvRestore <= nvData;
  end
  assign nvReady = 1'b1;
endmodule
`default_nettype wire

// File: tb/inertia_motor_step_control_tb.sv
// Self-checking bench for the inertia motor step controller.
// Assumes short hold, identify and blink counts set by parameter.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checkCount++; if ((g) !== (e)) begin errTotal++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module inertia_motor_step_control_tb;
  logic sys_clk = 1'b0, reset_n = 1'b0, chanEnable = 1'b1, faultIn = 1'b0, hostLoad = 1'b0;
  logic btnTop = 1'b0, btnBottom = 1'b0, nvReady, stepDir, moving, activeLed, errorLed, chanLed, nvWrite;
  logic [4:0] cmd = 5'h00;
  logic [1:0] jog = 2'h0;
  logic signed [7:0] pot = 8'sh00;
  logic [6:0] driveLevel, peakSeen = 7'h00;
  logic signed [31:0] moveTarget = 32'sh0, position;
  inertia_motor_pkg::settings_t hostSettings = inertia_motor_pkg::DEF_SETTINGS, nvRestore, nvData, exp;
  int errTotal = 0, checkCount = 0, lowN;
  ////////////////////////////////////////////////////////////////////////////
  initial forever #12.5 sys_clk = ~sys_clk;
  inertia_motor_step_control #(.HOLD_CYCLES(40), .IDENT_CYCLES(200), .BLINK_CYCLES(20)) dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .chanEnable(chanEnable), .faultIn(faultIn),
    .hostSettings(hostSettings), .hostLoad(hostLoad), .saveToNonvolatile(cmd[4]), .nvRestore(nvRestore),
    .nvReady(nvReady), .zeroCmd(cmd[0]), .stopCmd(cmd[1]), .moveCmd(cmd[2]), .moveTarget(moveTarget),
    .jogFwd(jog[0]), .jogRev(jog[1]), .identifyCmd(cmd[3]), .btnTop(btnTop), .btnBottom(btnBottom),
    .potDeflection(pot), .driveLevel(driveLevel), .stepDir(stepDir), .position(position),
    .moving(moving), .activeLed(activeLed), .errorLed(errorLed), .chanLed(chanLed), .nvWrite(nvWrite),
    .nvData(nvData));
  nv_store_model store (.sys_clk(sys_clk), .nvWrite(nvWrite), .nvData(nvData), .nvReady(nvReady),
    .nvRestore(nvRestore));
  // Highest drive level seen, to show the ramp reaches the peak setting.
  always @(posedge sys_clk)
  begin
    if (driveLevel > peakSeen)
      peakSeen <= driveLevel;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic pulse(input logic [4:0] c);
    cyc(1);
    cmd = c;
    cyc(1);
    cmd = 5'h00;
  endtask
  // Builds a settings word; target mode with the top button at step one.
  function automatic inertia_motor_pkg::settings_t mk(logic [10:0] v, logic [16:0] a, logic [6:0] p);
    mk = inertia_motor_pkg::DEF_SETTINGS;
    {mk.moveVel, mk.jogStep, mk.jogVel, mk.potMaxVel} = {v, v, v, v};
    {mk.moveAcc, mk.jogAcc, mk.peakVolt} = {a, a, p};
    mk.keyTargetMode = 1'b1;
    mk.topPos = 32'sh00000001;
  endfunction
  task automatic load(input inertia_motor_pkg::settings_t s, input inertia_motor_pkg::settings_t e);
    cyc(1);
    hostSettings = s;
    hostLoad = 1'b1;
    cyc(1);
    hostLoad = 1'b0;
    `CHK(nvData, e)
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checkCount, errTotal);
    if (errTotal == 0 && checkCount > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Watchdog; the whole run needs about 500 cycles.
  initial
  begin
    #100_000;
    errTotal++;
    conclude();
  end
  // Main sequence; inputs change 1 ns after the rising edge.
  initial
  begin
    cyc(3);
    `CHK(nvData, inertia_motor_pkg::DEF_SETTINGS)
    `CHK({stepDir, position, moving}, 34'h200000000)
    reset_n = 1'b1;
    cyc(3);
    exp = inertia_motor_pkg::DEF_SETTINGS;
    exp.jogStep = 11'h00A;
    exp.topPos = 32'sh00000003;
    `CHK(nvData, exp)
    $display("test restore done");
    load(mk(11'h000, 17'h00000, 7'h00), mk(11'h001, 17'h00001, 7'h55));
    load(mk(11'h7FF, 17'h1FFFF, 7'h7F), mk(11'h7D0, 17'h186A0, 7'h7D));
    load(mk(11'h7D0, 17'h186A0, 7'h64), mk(11'h7D0, 17'h186A0, 7'h64));
    pulse(5'h10);
    `CHK(nvWrite, 1'b1)
    cyc(1);
    `CHK(nvRestore, mk(11'h7D0, 17'h186A0, 7'h64))
    $display("test settings done");
    btnTop = 1'b1;
    cyc(3);
    btnTop = 1'b0;
    for (int n = 0; n < 20 && moving !== 1'b0; n++)
      cyc(1);
    `CHK(position, 32'sh00000001)
    `CHK(stepDir, 1'b1)
    cyc(110);
    `CHK(peakSeen, 7'h64)
    {btnTop, btnBottom} = 2'b11;
    cyc(45);
    `CHK(position, 32'sh00000000)
    {btnTop, btnBottom} = 2'b00;
    $display("test target and hold done");
    moveTarget = 32'sh00000064;
    pulse(5'h04);
    `CHK(moving, 1'b1)
    cyc(10);
    pulse(5'h02);
    `CHK({moving, position}, 33'h000000001)
    pulse(5'h01);
    `CHK(position, 32'sh00000000)
    jog = 2'h2;
    cyc(3);
    jog = 2'h0;
    pulse(5'h02);
    `CHK({stepDir, position}, 33'h0FFFFFFFF)
    pot = 8'shC0;
    cyc(3);
    pot = 8'sh00;
    cyc(2);
    `CHK({moving, position}, 33'h0FFFFFFFE)
    $display("test stop zero jog pot done");
    pulse(5'h08);
    lowN = 0;
    repeat (200)
    begin
      cyc(1);
      lowN += !chanLed;
    end
    `CHK(lowN > 50, 1'b1)
    cyc(20);
    `CHK(chanLed, 1'b1)
    $display("test identify done");
    faultIn = 1'b1;
    pulse(5'h04);
    `CHK({errorLed, activeLed, moving}, 3'b100)
    faultIn = 1'b0;
    chanEnable = 1'b0;
    cyc(2);
    `CHK({chanLed, moving, activeLed}, 3'b001)
    $display("test fault and enable done");
    conclude();
  end
endmodule
bind inertia_motor_step_control inertia_motor_step_control_props props (.sys_clk(sys_clk), .reset_n(reset_n),
  .chanEnable(chanEnable), .faultIn(faultIn), .hostSettings(hostSettings), .hostLoad(hostLoad),
  .saveToNonvolatile(saveToNonvolatile), .zeroCmd(zeroCmd), .stopCmd(stopCmd), .moveCmd(moveCmd),
  .driveLevel(driveLevel), .position(position), .moving(moving), .activeLed(activeLed),
  .errorLed(errorLed), .nvWrite(nvWrite), .nvData(nvData));
`default_nettype wire
